// ### core/udcr_pkg.sv
package udcr_pkg;

  // ****************************************************************
  // Register map (6-bit register addresses)
  // ****************************************************************
  localparam logic [5:0] ADDR_PIN_MODE_FAULT_TIMING = 6'h14;
  localparam logic [5:0] ADDR_DRIVE_SUPPLY_CONTROL = 6'h16;
  localparam logic [5:0] ADDR_ECHO_THRESHOLD_CONFIG = 6'h17;
  localparam logic [5:0] ADDR_ZERO_CROSS_CONFIG = 6'h18;
  localparam logic [5:0] ADDR_FAULT_STATUS = 6'h1c;

  // Reset values
  localparam logic [7:0] RST_PIN_MODE_FAULT_TIMING = 8'h00;
  localparam logic [7:0] RST_DRIVE_SUPPLY_CONTROL = 8'h20;
  localparam logic [7:0] RST_ECHO_THRESHOLD_CONFIG = 8'h07;
  localparam logic [7:0] RST_ZERO_CROSS_CONFIG = 8'h14;

  // Writable bit masks; everything else reads zero
  localparam logic [7:0] MASK_PIN_MODE_FAULT_TIMING = 8'h1f;
  localparam logic [7:0] MASK_DRIVE_SUPPLY_CONTROL = 8'h7f;
  localparam logic [7:0] MASK_ECHO_THRESHOLD_CONFIG = 8'h1f;
  localparam logic [7:0] MASK_ZERO_CROSS_CONFIG = 8'hff;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PIN_MODE_LSB = 0;
  localparam int DEGLITCH_SEL_LSB = 2;
  localparam int AUTO_OFF_BIT = 6;
  localparam int HIGH_Z_BIT = 5;
  localparam int PULLUP_CUR_BIT = 4;
  localparam int TARGET_V_LSB = 0;
  localparam int ECHO_EN_BIT = 4;
  localparam int ECHO_CODE_LSB = 0;
  localparam int ZC_EN_BIT = 7;
  localparam int ZC_GATE_BIT = 6;
  localparam int ZC_INSEL_BIT = 5;
  localparam int ZC_STAGE_LSB = 3;
  localparam int ZC_HYST_LSB = 0;
  localparam int STUCK_FAULT_BIT = 1;

  // ****************************************************************
  // Serial frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 16;
  localparam int HEADER_BITS = 8;
  localparam logic [4:0] FRAME_BITS_5 = 5'd16;
  localparam logic [4:0] HEADER_BITS_5 = 5'd8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 40_000_000;
  // Cycles per microsecond; the plain product of hertz and microseconds overflows int
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam logic [11:0] DEGLITCH_0_CYC = 12'(64 * CLK_MHZ);
  localparam logic [11:0] DEGLITCH_1_CYC = 12'(48 * CLK_MHZ);
  localparam logic [11:0] DEGLITCH_2_CYC = 12'(32 * CLK_MHZ);
  localparam logic [11:0] DEGLITCH_3_CYC = 12'(24 * CLK_MHZ);
  localparam logic [11:0] DEGLITCH_4_CYC = 12'(16 * CLK_MHZ);
  localparam logic [11:0] DEGLITCH_5_CYC = 12'(8 * CLK_MHZ);
  localparam logic [11:0] DEGLITCH_6_CYC = 12'(4 * CLK_MHZ);
  localparam logic [2:0] DEGLITCH_OFF = 3'h7;

  // ****************************************************************
  // Analog setting scales (millivolts; supply base in volts)
  // ****************************************************************
  localparam logic [10:0] THR_LOW_STEP_MV = 11'd40;
  localparam logic [10:0] THR_LOW_BASE_MV = 11'd400;
  localparam logic [10:0] THR_HIGH_STEP_MV = 11'd60;
  localparam logic [10:0] THR_HIGH_BASE_MV = 11'd600;
  localparam logic [8:0] HYST_STEP_MV = 9'd50;
  localparam logic [8:0] HYST_BASE_MV = 9'd30;
  localparam logic [4:0] SUPPLY_BASE_V = 5'd5;

  // Pin modes
  typedef enum logic [1:0] {
    UDCR_MODE0 = 2'b00,
    UDCR_MODE1 = 2'b01,
    UDCR_MODE2 = 2'b10,
    UDCR_MODE3 = 2'b11
  } udcr_pin_mode_t;

endpackage : udcr_pkg

// ### core/udcr_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for one asynchronous level
module udcr_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Level
  input wire logic async_in,
  output logic sync_out
);

  logic meta;

  // First stage is read only by the second stage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : udcr_sync

// ### core/udcr_regs.sv
//
// Contract
// - Modes 0/1: second pin silence sets fault
// - Mode 2: either pin silent sets fault
// - Deglitch code selects 64 to 4 us
// - Code 7 disables the toggle check
// - Two-bit pin mode, resets to 0
// - Auto-off stops charging after burst exit
// - High-impedance bit kills source and regulation
// - Pull-up current: 10 or 20 mA
// - Supply target equals code plus five volts
// - Threshold output driven only when enabled
// - Echo threshold from code and scale
// - Zero-cross comparator enabled by its bit
// - Gating bit: zero-cross only on object
// - Input select: common-mode or negative input
// - Stage select two bits, resets to 2
// - Hysteresis 30 to 380 mV, reset 4
// - Stuck fault readable as status bit
// - Scale bit picks 3.3 V or 5 V
//
`timescale 1ns/1ps
module udcr_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Serial port from the host (asynchronous pins)
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Low-voltage control pins (asynchronous)
  input wire logic first_control_pin,
  input wire logic second_control_pin,
  // Device logic on this clock
  input wire logic burst_active,
  input wire logic supply_charge_trigger,
  input wire logic output_scale_sel,
  // Analog comparators (asynchronous)
  input wire logic echo_cmp_raw,
  input wire logic zero_cross_raw,
  // Outputs to pins and analog blocks
  output logic threshold_output_pin,
  output logic zero_cross_out,
  output logic driver_stuck_fault,
  output udcr_pkg::udcr_pin_mode_t pin_mode,
  output logic supply_charge_on,
  output logic supply_regulate_en,
  output logic supply_pullup_current_sel,
  output logic [4:0] supply_target_volts,
  output logic [10:0] echo_threshold_mv,
  output logic zero_cross_enable,
  output logic zero_cross_input_select,
  output logic [1:0] zero_cross_stage_select,
  output logic [8:0] zero_cross_hysteresis_mv
);
  import udcr_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic sclk_s, cs_n_s, mosi_s, pin1_s, pin2_s, echo_s, zc_s;

  udcr_sync #(.RESET_VALUE(1'b0)) u_sync_sclk (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(spi_sclk), .sync_out(sclk_s));
  udcr_sync #(.RESET_VALUE(1'b1)) u_sync_cs (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(spi_cs_n), .sync_out(cs_n_s));
  udcr_sync #(.RESET_VALUE(1'b0)) u_sync_mosi (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(spi_mosi), .sync_out(mosi_s));
  udcr_sync #(.RESET_VALUE(1'b0)) u_sync_pin1 (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(first_control_pin), .sync_out(pin1_s));
  udcr_sync #(.RESET_VALUE(1'b0)) u_sync_pin2 (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(second_control_pin), .sync_out(pin2_s));
  udcr_sync #(.RESET_VALUE(1'b0)) u_sync_echo (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(echo_cmp_raw), .sync_out(echo_s));
  udcr_sync #(.RESET_VALUE(1'b0)) u_sync_zc (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(zero_cross_raw), .sync_out(zc_s));

  // Delayed copies for edge detection; serial clock and pin copies taken after the synchronisers, burst copy taken directly
  logic sclk_d, pin1_d, pin2_d, burst_d;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d <= 1'b0;
      pin1_d <= 1'b0;
      pin2_d <= 1'b0;
      burst_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      pin1_d <= pin1_s;
      pin2_d <= pin2_s;
      burst_d <= burst_active;
    end
  end

  logic sclk_rise, sclk_fall, burst_start, burst_exit;
  assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
  assign burst_start = burst_active & ~burst_d;
  assign burst_exit = ~burst_active & burst_d;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] pin_mode_fault_timing;
  logic [7:0] drive_supply_control;
  logic [7:0] echo_threshold_config;
  logic [7:0] zero_cross_config;

  logic [4:0] bit_cnt;
  logic [14:0] rx_shift;
  logic [7:0] tx_shift;
  logic is_read;
  logic [5:0] frame_addr;
  logic wr_strobe;
  logic [7:0] wr_data;

  // Header: bit 15 read flag, bits 14:9 address, bit 8 ignored
  assign is_read = rx_shift[7];
  assign frame_addr = rx_shift[6:1];

  // Receive shifter; mode 0 style, sample on rising serial clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 5'd0;
      rx_shift <= 15'h0000;
      wr_strobe <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_strobe <= 1'b0;
      if (cs_n_s) begin
        bit_cnt <= 5'd0;
      end else if (sclk_rise) begin
        bit_cnt <= bit_cnt + 5'd1;
        rx_shift <= {rx_shift[13:0], mosi_s};
        // Commit only a complete frame; a short frame writes nothing
        if (bit_cnt == FRAME_BITS_5 - 5'd1) begin
          wr_data <= {rx_shift[6:0], mosi_s};
          wr_strobe <= ~rx_shift[14];
        end
      end
    end
  end

  // Write decode; the commit shift has moved the address to the top bits
  logic [5:0] wr_addr;
  assign wr_addr = rx_shift[14:9];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_mode_fault_timing <= RST_PIN_MODE_FAULT_TIMING;
      drive_supply_control <= RST_DRIVE_SUPPLY_CONTROL;
      echo_threshold_config <= RST_ECHO_THRESHOLD_CONFIG;
      zero_cross_config <= RST_ZERO_CROSS_CONFIG;
    end else if (wr_strobe) begin
      // Reserved bits are masked off and stay zero
      unique case (wr_addr)
        ADDR_PIN_MODE_FAULT_TIMING: begin
          pin_mode_fault_timing <= wr_data & MASK_PIN_MODE_FAULT_TIMING;
        end
        ADDR_DRIVE_SUPPLY_CONTROL: begin
          drive_supply_control <= wr_data & MASK_DRIVE_SUPPLY_CONTROL;
        end
        ADDR_ECHO_THRESHOLD_CONFIG: begin
          echo_threshold_config <= wr_data & MASK_ECHO_THRESHOLD_CONFIG;
        end
        ADDR_ZERO_CROSS_CONFIG: begin
          zero_cross_config <= wr_data & MASK_ZERO_CROSS_CONFIG;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data mux; unmapped addresses read zero
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    unique case (frame_addr)
      ADDR_PIN_MODE_FAULT_TIMING: rd_data = pin_mode_fault_timing;
      ADDR_DRIVE_SUPPLY_CONTROL: rd_data = drive_supply_control;
      ADDR_ECHO_THRESHOLD_CONFIG: rd_data = echo_threshold_config;
      ADDR_ZERO_CROSS_CONFIG: rd_data = zero_cross_config;
      ADDR_FAULT_STATUS: rd_data[STUCK_FAULT_BIT] = driver_stuck_fault;
      default: rd_data = 8'h00;
    endcase
  end

  // Transmit shifter: zeros during the header, data after it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_shift <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= ~cs_n_s;
      if (cs_n_s) begin
        tx_shift <= 8'h00;
        spi_miso <= 1'b0;
      end else if (sclk_fall) begin
        if (bit_cnt == HEADER_BITS_5 && is_read) begin
          spi_miso <= rd_data[7];
          tx_shift <= {rd_data[6:0], 1'b0};
        end else begin
          spi_miso <= tx_shift[7];
          tx_shift <= {tx_shift[6:0], 1'b0};
        end
      end
    end
  end

  // ****************************************************************
  // Driver stuck monitor
  // ****************************************************************
  logic [2:0] deglitch_sel;
  logic [11:0] limit_cyc;
  logic [11:0] silent1_cnt, silent2_cnt;
  logic check_on, both_high, over1, over2;
  udcr_pin_mode_t mode_now;

  assign mode_now = udcr_pin_mode_t'(pin_mode_fault_timing[PIN_MODE_LSB +: 2]);
  assign deglitch_sel = pin_mode_fault_timing[DEGLITCH_SEL_LSB +: 3];
  assign check_on = burst_active && deglitch_sel != DEGLITCH_OFF;
  assign both_high = pin1_s & pin2_s;

  // Limit lookup; the check is off for the last code
  always_comb begin
    limit_cyc = DEGLITCH_0_CYC;
    unique case (deglitch_sel)
      3'h0: limit_cyc = DEGLITCH_0_CYC;
      3'h1: limit_cyc = DEGLITCH_1_CYC;
      3'h2: limit_cyc = DEGLITCH_2_CYC;
      3'h3: limit_cyc = DEGLITCH_3_CYC;
      3'h4: limit_cyc = DEGLITCH_4_CYC;
      3'h5: limit_cyc = DEGLITCH_5_CYC;
      3'h6: limit_cyc = DEGLITCH_6_CYC;
      3'h7: limit_cyc = DEGLITCH_0_CYC;
    endcase
  end

  // Silence timers restart on each toggle; they saturate past the limit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      silent1_cnt <= 12'h000;
      silent2_cnt <= 12'h000;
    end else begin
      if (!check_on || burst_start || pin1_s != pin1_d || both_high) begin
        silent1_cnt <= 12'h000;
      end else if (!over1) begin
        silent1_cnt <= silent1_cnt + 12'h001;
      end
      if (!check_on || burst_start || pin2_s != pin2_d || both_high) begin
        silent2_cnt <= 12'h000;
      end else if (!over2) begin
        silent2_cnt <= silent2_cnt + 12'h001;
      end
    end
  end

  assign over1 = silent1_cnt > limit_cyc;
  assign over2 = silent2_cnt > limit_cyc;

  // Fault is sticky until the next burst start; a new set wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      driver_stuck_fault <= 1'b0;
    end else begin
      unique case (mode_now)
        UDCR_MODE0, UDCR_MODE1: begin
          if (check_on && over2) begin
            driver_stuck_fault <= 1'b1;
          end else if (burst_start) begin
            driver_stuck_fault <= 1'b0;
          end
        end
        UDCR_MODE2: begin
          // Both pins high resets both timers, so that state never faults
          if (check_on && (over1 || over2)) begin
            driver_stuck_fault <= 1'b1;
          end else if (burst_start) begin
            driver_stuck_fault <= 1'b0;
          end
        end
        UDCR_MODE3: begin
          if (burst_start) begin
            driver_stuck_fault <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Drive supply control
  // ****************************************************************
  logic listen_hold;

  // With auto-off, charging waits for the trigger from a burst exit until the next burst start
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      listen_hold <= 1'b0;
    end else if (burst_start) begin
      listen_hold <= 1'b0;
    end else if (burst_exit) begin
      listen_hold <= 1'b1;
    end
  end

  // Analog settings registered so every output is a flop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_mode <= UDCR_MODE0;
      supply_charge_on <= 1'b0;
      supply_regulate_en <= 1'b0;
      supply_pullup_current_sel <= 1'b0;
      supply_target_volts <= SUPPLY_BASE_V;
    end else begin
      pin_mode <= mode_now;
      supply_charge_on <= ~drive_supply_control[HIGH_Z_BIT] &
        (~drive_supply_control[AUTO_OFF_BIT] | supply_charge_trigger | ~listen_hold);
      supply_regulate_en <= ~drive_supply_control[HIGH_Z_BIT];
      supply_pullup_current_sel <= drive_supply_control[PULLUP_CUR_BIT];
      supply_target_volts <= {1'b0, drive_supply_control[TARGET_V_LSB +: 4]}
        + SUPPLY_BASE_V;
    end
  end

  // ****************************************************************
  // Echo threshold and zero-cross
  // ****************************************************************
  logic [10:0] echo_code;
  assign echo_code = {7'h00, echo_threshold_config[ECHO_CODE_LSB +: 4]};

  // Products stay within 11 bits: 60 * 15 + 600 = 1500
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      echo_threshold_mv <= THR_LOW_BASE_MV;
      threshold_output_pin <= 1'b0;
      zero_cross_out <= 1'b0;
      zero_cross_enable <= 1'b0;
      zero_cross_input_select <= 1'b0;
      zero_cross_stage_select <= 2'h2;
      zero_cross_hysteresis_mv <= HYST_BASE_MV;
    end else begin
      echo_threshold_mv <= output_scale_sel ?
        11'(echo_code * THR_HIGH_STEP_MV + THR_HIGH_BASE_MV) :
        11'(echo_code * THR_LOW_STEP_MV + THR_LOW_BASE_MV);
      threshold_output_pin <= echo_threshold_config[ECHO_EN_BIT] & echo_s;
      zero_cross_out <= zero_cross_config[ZC_EN_BIT] & zc_s &
        (~zero_cross_config[ZC_GATE_BIT] | echo_s);
      zero_cross_enable <= zero_cross_config[ZC_EN_BIT];
      zero_cross_input_select <= zero_cross_config[ZC_INSEL_BIT];
      zero_cross_stage_select <= zero_cross_config[ZC_STAGE_LSB +: 2];
      zero_cross_hysteresis_mv <= 9'(zero_cross_config[ZC_HYST_LSB +: 3] * HYST_STEP_MV
        + HYST_BASE_MV);
    end
  end

endmodule : udcr_regs

// ### verification/udcr_regs_props.sv
`timescale 1ns/1ps
// ********************
// Port checker for the register bank
// ********************
module udcr_regs_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Pins and device inputs
  input wire logic first_control_pin,
  input wire logic second_control_pin,
  input wire logic burst_active,
  input wire logic output_scale_sel,
  input wire logic echo_cmp_raw,
  // Outputs watched
  input wire logic threshold_output_pin,
  input wire logic zero_cross_out,
  input wire logic driver_stuck_fault,
  input wire udcr_pkg::udcr_pin_mode_t pin_mode,
  input wire logic supply_charge_on,
  input wire logic supply_regulate_en,
  input wire logic [4:0] supply_target_volts,
  input wire logic [10:0] echo_threshold_mv,
  input wire logic zero_cross_enable,
  input wire logic [8:0] zero_cross_hysteresis_mv
);
  import udcr_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // Quiet time of each raw pin; saturates so a long idle never wraps
  logic l1, l2;
  logic [11:0] q1, q2;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      l1 <= 1'b0;
      l2 <= 1'b0;
      q1 <= 12'h000;
      q2 <= 12'h000;
    end else begin
      l1 <= first_control_pin;
      l2 <= second_control_pin;
      q1 <= (first_control_pin != l1) ? 12'h000 : q1 + {11'h000, ~&q1};
      q2 <= (second_control_pin != l2) ? 12'h000 : q2 + {11'h000, ~&q2};
    end
  end

  // ********************
  // Assertions
  // ********************
  a_charge_needs_reg: assert property (supply_charge_on |-> supply_regulate_en)
    else $error("charging while regulation is off");
  a_target_range: assert property (supply_target_volts inside {[5'd5:5'd20]})
    else $error("supply target outside code plus five");
  a_thr_scale: assert property ($past(arst_n) |-> ($past(output_scale_sel)
    ? (echo_threshold_mv inside {[11'd600:11'd1500]} && (echo_threshold_mv % 11'd60) == 0)
    : (echo_threshold_mv inside {[11'd400:11'd1000]} && (echo_threshold_mv % 11'd40) == 0)))
    else $error("echo threshold off its scale");
  a_hyst_steps: assert property (zero_cross_hysteresis_mv inside {[9'd30:9'd380]}
    && ((zero_cross_hysteresis_mv - 9'd30) % 9'd50) == 0)
    else $error("hysteresis off its steps");
  a_zc_needs_en: assert property (zero_cross_out |-> zero_cross_enable)
    else $error("zero-cross output while disabled");
  a_thr_cause: assert property (threshold_output_pin |->
    $past(echo_cmp_raw, 2) || $past(echo_cmp_raw, 3) || $past(echo_cmp_raw, 4))
    else $error("threshold pin high without comparator");
  a_fault_in_burst: assert property ($rose(driver_stuck_fault) |-> $past(burst_active))
    else $error("fault raised outside burst");
  a_fault_quiet: assert property ($rose(driver_stuck_fault) |->
    (pin_mode == UDCR_MODE2) ? (q1 >= 12'd160 || q2 >= 12'd160) : q2 >= 12'd160)
    else $error("fault raised before the pin was quiet long enough");
  a_mode3_quiet: assert property ($rose(driver_stuck_fault) |-> $past(pin_mode) != UDCR_MODE3)
    else $error("fault raised in mode 3");
  a_fault_clear: assert property ($fell(driver_stuck_fault) |-> $past(burst_active)
    && (!$past(burst_active, 2) || !$past(burst_active, 3)))
    else $error("fault cleared away from a burst start");
endmodule : udcr_regs_props

bind udcr_regs udcr_regs_props u_udcr_regs_props (.*);

// ### verification/udcr_spi_host.sv
`timescale 1ns/1ps
// ********************
// Host model: drives 16-bit serial frames
// ********************
module udcr_spi_host (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // Six clocks per phase, above the three-clock minimum of the port
  localparam int HALF = 6;

  // Idle lines
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // One frame, first bit first; read data caught on rising edges
  task automatic xfer(input logic [15:0] w, output logic [7:0] r);
    r = 8'h00;
    @(negedge sys_clk);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = w[i];
      repeat (HALF) @(negedge sys_clk);
      spi_sclk = 1'b1;
      if (i < 8) r[i] = spi_miso;
      repeat (HALF) @(negedge sys_clk);
      spi_sclk = 1'b0;
    end
    repeat (HALF) @(negedge sys_clk);
    spi_cs_n = 1'b1;
    // Released data line must not keep its last value
    spi_mosi = ~spi_mosi;
    repeat (4) @(negedge sys_clk);
  endtask : xfer
endmodule : udcr_spi_host

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import udcr_pkg::*;

  // ********************
  // Signals
  // ********************
  logic sys_clk, arst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic first_control_pin, second_control_pin, burst_active, supply_charge_trigger;
  logic output_scale_sel, echo_cmp_raw, zero_cross_raw, threshold_output_pin;
  logic zero_cross_out, driver_stuck_fault, supply_charge_on, supply_regulate_en;
  logic supply_pullup_current_sel, zero_cross_enable, zero_cross_input_select;
  udcr_pin_mode_t pin_mode;
  logic [4:0] supply_target_volts;
  logic [10:0] echo_threshold_mv;
  logic [1:0] zero_cross_stage_select;
  logic [8:0] zero_cross_hysteresis_mv;
  int mismatches, n_tests, cycles;

  udcr_regs u_udcr_regs (.*);
  udcr_spi_host u_host (.*);

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the roughly 26k cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      wrap_up;
    end
  end

  // ********************
  // Helpers
  // ********************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_host.xfer({1'b0, a, 1'b0, d}, r);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] r;
    u_host.xfer({1'b1, a, 9'h000}, r);
    chk({8'h00, r}, {8'h00, exp});
  endtask : rd

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset;
    rd(ADDR_PIN_MODE_FAULT_TIMING, 8'h00);
    rd(ADDR_DRIVE_SUPPLY_CONTROL, 8'h20);
    rd(ADDR_ECHO_THRESHOLD_CONFIG, 8'h07);
    rd(ADDR_ZERO_CROSS_CONFIG, 8'h14);
    rd(ADDR_FAULT_STATUS, 8'h00);
    chk(16'(spi_miso_oe), 16'h0000);
    chk(16'(supply_regulate_en), 16'h0000);
    chk(16'(zero_cross_hysteresis_mv), 16'd230);
    chk(16'(echo_threshold_mv), 16'd680);
    $display("test reset done");
  endtask : t_reset

  // Writes every field, reserved and unmapped places included
  task automatic t_regs;
    wr(ADDR_PIN_MODE_FAULT_TIMING, 8'hff);
    rd(ADDR_PIN_MODE_FAULT_TIMING, 8'h1f);
    chk(16'(pin_mode), 16'h0003);
    wr(ADDR_DRIVE_SUPPLY_CONTROL, 8'hbf);
    rd(ADDR_DRIVE_SUPPLY_CONTROL, 8'h3f);
    chk(16'(supply_regulate_en), 16'h0000);
    chk(16'(supply_target_volts), 16'd20);
    chk(16'(supply_pullup_current_sel), 16'h0001);
    wr(ADDR_DRIVE_SUPPLY_CONTROL, 8'h03);
    chk(16'(supply_regulate_en), 16'h0001);
    chk(16'(supply_target_volts), 16'd8);
    chk(16'(supply_pullup_current_sel), 16'h0000);
    wr(ADDR_ECHO_THRESHOLD_CONFIG, 8'hef);
    rd(ADDR_ECHO_THRESHOLD_CONFIG, 8'h0f);
    chk(16'(echo_threshold_mv), 16'd1000);
    output_scale_sel = 1'b1;
    tick(3);
    chk(16'(echo_threshold_mv), 16'd1500);
    output_scale_sel = 1'b0;
    wr(ADDR_ZERO_CROSS_CONFIG, 8'h6b);
    rd(ADDR_ZERO_CROSS_CONFIG, 8'h6b);
    chk(16'(zero_cross_stage_select), 16'h0001);
    chk(16'(zero_cross_hysteresis_mv), 16'd180);
    chk(16'(zero_cross_input_select), 16'h0001);
    chk(16'(zero_cross_enable), 16'h0000);
    wr(6'h15, 8'hff);
    rd(6'h15, 8'h00);
    wr(ADDR_FAULT_STATUS, 8'hff);
    rd(ADDR_FAULT_STATUS, 8'h00);
    $display("test registers done");
  endtask : t_regs

  task automatic t_supply;
    wr(ADDR_DRIVE_SUPPLY_CONTROL, 8'h40);
    chk(16'(supply_charge_on), 16'h0001);
    burst_active = 1'b1;
    tick(3);
    burst_active = 1'b0;
    tick(3);
    chk(16'(supply_charge_on), 16'h0000);
    supply_charge_trigger = 1'b1;
    tick(3);
    chk(16'(supply_charge_on), 16'h0001);
    supply_charge_trigger = 1'b0;
    tick(3);
    chk(16'(supply_charge_on), 16'h0000);
    wr(ADDR_DRIVE_SUPPLY_CONTROL, 8'h00);
    chk(16'(supply_charge_on), 16'h0001);
    $display("test supply done");
  endtask : t_supply

  task automatic t_outputs;
    echo_cmp_raw = 1'b1;
    zero_cross_raw = 1'b1;
    wr(ADDR_ECHO_THRESHOLD_CONFIG, 8'h00);
    chk(16'(threshold_output_pin), 16'h0000);
    wr(ADDR_ECHO_THRESHOLD_CONFIG, 8'h10);
    chk(16'(threshold_output_pin), 16'h0001);
    echo_cmp_raw = 1'b0;
    wr(ADDR_ZERO_CROSS_CONFIG, 8'hc0);
    chk(16'(zero_cross_out), 16'h0000);
    echo_cmp_raw = 1'b1;
    tick(5);
    chk(16'(zero_cross_out), 16'h0001);
    wr(ADDR_ZERO_CROSS_CONFIG, 8'h00);
    chk(16'(zero_cross_out), 16'h0000);
    $display("test outputs done");
  endtask : t_outputs

  // Burst with pins toggling every 20 clocks; a pin whose flag is clear stops at 180
  task automatic t_fault(input logic [1:0] m, input logic [2:0] c,
                         input logic t1, input logic t2, input logic hi, input logic exp);
    int us[8] = '{64, 48, 32, 24, 16, 8, 4, 65};
    int lim;
    lim = 40 * us[c];
    wr(ADDR_PIN_MODE_FAULT_TIMING, {3'h0, c, m});
    first_control_pin = hi;
    second_control_pin = hi;
    burst_active = 1'b1;
    tick(4);
    chk(16'(driver_stuck_fault), 16'h0000);
    for (int n = 0; n < 212 + lim; n++) begin
      if (n == 178 + lim) chk(16'(driver_stuck_fault), 16'h0000);
      if (n % 20 == 0 && !hi && (n < 200 || t1)) first_control_pin = ~first_control_pin;
      if (n % 20 == 0 && !hi && (n < 200 || t2)) second_control_pin = ~second_control_pin;
      tick(1);
    end
    chk(16'(driver_stuck_fault), 16'(exp));
    rd(ADDR_FAULT_STATUS, {6'h00, exp, 1'b0});
    burst_active = 1'b0;
    tick(4);
    $display("test fault done");
  endtask : t_fault

  // ********************
  // Main sequence
  // ********************
  initial begin
    arst_n = 1'b0;
    first_control_pin = 1'b0;
    second_control_pin = 1'b0;
    burst_active = 1'b0;
    supply_charge_trigger = 1'b0;
    output_scale_sel = 1'b0;
    echo_cmp_raw = 1'b0;
    zero_cross_raw = 1'b0;
    tick(20);
    arst_n = 1'b1;
    tick(4);
    t_reset;
    t_regs;
    t_supply;
    t_outputs;
    for (int c = 0; c < 7; c++) t_fault(2'h0, 3'(c), 1'b1, 1'b0, 1'b0, 1'b1);
    t_fault(2'h1, 3'h3, 1'b1, 1'b0, 1'b0, 1'b1);
    t_fault(2'h0, 3'h5, 1'b0, 1'b1, 1'b0, 1'b0);
    t_fault(2'h0, 3'h7, 1'b1, 1'b0, 1'b0, 1'b0);
    t_fault(2'h2, 3'h5, 1'b0, 1'b1, 1'b0, 1'b1);
    t_fault(2'h2, 3'h5, 1'b0, 1'b0, 1'b1, 1'b0);
    t_fault(2'h3, 3'h6, 1'b0, 1'b0, 1'b0, 1'b0);
    wrap_up;
  end
endmodule : tb_top
